// ==== hdl/timer_pkg.sv ====
// Purpose: Shared constants for the gated 16-bit timer/counter
// Assumes: AHB-Lite register bus, one 100 MHz clock
// Notes:   Every offset, field position and count lives here, with the control, gate, clock select and count reset values
package timer_pkg;

	// ==========================================================
	// Register map (byte addresses, one word each)
	localparam logic [4:0] OFS_COUNT_LOW  = 5'h00;
	localparam logic [4:0] OFS_COUNT_HIGH = 5'h04;
	localparam logic [4:0] OFS_TIMER_CTRL = 5'h08;
	localparam logic [4:0] OFS_GATE_CTRL  = 5'h0C;
	localparam logic [4:0] OFS_CLOCK_SEL  = 5'h10;
	localparam logic [4:0] OFS_IRQ_STATUS = 5'h14;
	localparam logic [4:0] OFS_IRQ_MASK   = 5'h18;

	// ==========================================================
	// Field positions
	localparam int unsigned CTRL_RUN_BIT   = 0;
	localparam int unsigned CTRL_BUF_BIT   = 1;
	localparam int unsigned CTRL_ASYNC_BIT = 2;
	localparam int unsigned CTRL_PS_LSB    = 4;
	localparam int unsigned GATE_EN_BIT    = 7;
	localparam int unsigned STAT_OVF_BIT   = 0;

	// ==========================================================
	// Reset values
	localparam logic [7:0]  CTRL_RESET   = 8'h00;
	localparam logic [7:0]  GATE_RESET   = 8'h00;
	localparam logic [1:0]  CLKSEL_RESET = 2'h0;
	localparam logic [15:0] COUNT_RESET  = 16'h0000;

	// ==========================================================
	// Clock source selections
	localparam logic [1:0] CLK_INSTR = 2'h0;
	localparam logic [1:0] CLK_OSC   = 2'h1;
	localparam logic [1:0] CLK_EXT   = 2'h2;

	// ==========================================================
	// Timing: instruction cycle is four system clocks
	localparam int unsigned CLK_PERIOD_NS  = 10;
	localparam int unsigned INSTR_PERIOD_NS = 40;
	localparam int unsigned CLKS_PER_INSTR = INSTR_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [1:0]  INSTR_LAST     = 2'(CLKS_PER_INSTR - 1);

	// ==========================================================
	// AHB-Lite transfer codes
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ    = 2'h3;

	// Bus slave states, one-hot
	typedef enum logic [2:0] {
		BUS_IDLE  = 3'b001,
		BUS_RWAIT = 3'b010,
		BUS_RDONE = 3'b100
	} bus_state_t;

endpackage : timer_pkg

// ==== hdl/sync_edge.sv ====
// Purpose: Two-stage synchroniser with rising-edge detect
// Assumes: Input may change at any time
// Notes:   First stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none
module sync_edge
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Raw input
	input  wire logic din,
	// Synchronised level and rising edge
	output logic      level,
	output logic      rise
);

	logic stage1_r;
	logic stage2_r;
	logic prev_r;

	// Synchroniser chain and delayed copy
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			stage1_r <= 1'b0;
			stage2_r <= 1'b0;
			prev_r   <= 1'b0;
		end
		else
		begin
			stage1_r <= din;
			stage2_r <= stage1_r;
			prev_r   <= stage2_r;
		end
	end

	// Outputs look only at stage two and later
	assign level = stage2_r;
	assign rise  = stage2_r & ~prev_r;

endmodule : sync_edge
`default_nettype wire

// ==== hdl/prescale_divider.sv ====
// Purpose: Divide a tick stream by 1, 2, 4 or 8
// Assumes: tickIn counts once per clock it is high; it may stay high
// Notes:   Clear wins over counting; count is not visible to software
`timescale 1ns/100ps
`default_nettype none
module prescale_divider
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Control
	input  wire logic       clear,
	input  wire logic [1:0] sel,
	// Ticks
	input  wire logic       tickIn,
	output logic            tickOut
);

	logic [2:0] cnt_r;
	logic [2:0] divMask;

	// Terminal mask for the selected ratio
	assign divMask = 3'((4'h1 << sel) - 4'h1);
	assign tickOut = tickIn & ((cnt_r & divMask) == divMask);

	// Prescale counter
	always_ff @(posedge clk)
	begin
		if (rst || clear)
			cnt_r <= 3'h0;
		else if (tickIn)
			cnt_r <= 3'(cnt_r + 3'h1);
	end

endmodule : prescale_divider
`default_nettype wire

// ==== hdl/gated_timer_counter.sv ====
// Purpose: 16-bit gated timer/counter with AHB-Lite registers
// Assumes: One clock, synchronous active-high reset, word accesses
// Notes:   Gate source logic lives outside; gateOpen is its result
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - 16-bit up counter, byte writes update directly
// - Run enable off stops; gate enable gates
// - Instruction clock advances once per cycle
// - Oscillator clock advances four per instruction
// - Clock select picks internal or external source
// - External source counts on rising edges
// - External count synchronous or asynchronous
// - Falling edge needed before first counted rise
// - Prescaler divides by 1, 2, 4, 8
// - Prescaler hidden, cleared on counter writes
// - Buffered mode maps high address to buffer
// - Low read copies high byte into buffer
// - Low write loads high from buffer together
// - Buffered high writes leave prescaler alone
module gated_timer_counter
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// Count sources
	input  wire logic        externalCountInput,
	input  wire logic        gateOpen,
	// Interrupt
	output logic             irq
);
	import timer_pkg::*;

	// ==========================================================
	// Registers
	logic [15:0]  count_r;
	logic [15:0]  count_nxt;
	logic [7:0]   highBuf_r;
	logic [7:0]   ctrl_r;
	logic [7:0]   gateCtrl_r;
	logic [1:0]   clkSel_r;
	logic         status_r;
	logic         mask_r;
	logic         armed_r;
	logic         runPrev_r;
	logic         extPend_r;
	logic [1:0]   instrPhase_r;
	logic [31:0]  hrdata_r;
	bus_state_t   busState_r;
	logic [4:0]   dAddr_r;
	logic         dWrite_r;

	// ==========================================================
	// Register field views
	logic       runEnable;
	logic       bufferedAccess;
	logic       asyncMode;
	logic [1:0] prescaleSelect;
	logic       gateEnable;

	assign runEnable      = ctrl_r[CTRL_RUN_BIT];
	assign bufferedAccess = ctrl_r[CTRL_BUF_BIT];
	assign asyncMode      = ctrl_r[CTRL_ASYNC_BIT];
	assign prescaleSelect = ctrl_r[CTRL_PS_LSB +: 2];
	assign gateEnable     = gateCtrl_r[GATE_EN_BIT];

	// ==========================================================
	// Bus address phase and decode
	function automatic logic isAddr(input logic [4:0] a, input logic [4:0] ofs);
		isAddr = (a == ofs);
	endfunction : isAddr

	logic       addrValid;
	logic       takeRead;
	logic       takeWrite;
	logic       wrPhase;
	logic       wrLow;
	logic       wrHigh;
	logic       wrCtrl;
	logic       wrGate;
	logic       wrClk;
	logic       wrStat;
	logic       wrMask;
	logic       rdLowNow;

	// Transfer is taken when selected, active and the bus is ready
	assign addrValid = hsel && hready &&
		(htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
	assign takeRead  = addrValid && !hwrite && (busState_r == BUS_IDLE ||
		busState_r == BUS_RDONE);
	assign takeWrite = addrValid && hwrite && (busState_r == BUS_IDLE ||
		busState_r == BUS_RDONE);

	// Write data phase decode
	assign wrPhase = dWrite_r && (busState_r == BUS_IDLE);
	assign wrLow   = wrPhase && isAddr(dAddr_r, OFS_COUNT_LOW);
	assign wrHigh  = wrPhase && isAddr(dAddr_r, OFS_COUNT_HIGH);
	assign wrCtrl  = wrPhase && isAddr(dAddr_r, OFS_TIMER_CTRL);
	assign wrGate  = wrPhase && isAddr(dAddr_r, OFS_GATE_CTRL);
	assign wrClk   = wrPhase && isAddr(dAddr_r, OFS_CLOCK_SEL);
	assign wrStat  = wrPhase && isAddr(dAddr_r, OFS_IRQ_STATUS);
	assign wrMask  = wrPhase && isAddr(dAddr_r, OFS_IRQ_MASK);

	// Read of the low byte happens in the wait cycle of its data phase
	assign rdLowNow = (busState_r == BUS_RWAIT) && isAddr(dAddr_r, OFS_COUNT_LOW);

	// Bus phase tracking
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			busState_r <= BUS_IDLE;
			dAddr_r    <= 5'h00;
			dWrite_r   <= 1'b0;
		end
		else
		begin
			if (takeRead)
				busState_r <= BUS_RWAIT;
			else if (busState_r == BUS_RWAIT)
				busState_r <= BUS_RDONE;
			else
				busState_r <= BUS_IDLE;
			if (takeRead || takeWrite)
				dAddr_r <= haddr[4:0];
			dWrite_r <= takeWrite;
		end
	end

	// Reads wait one cycle; writes finish at once
	assign hreadyout = (busState_r != BUS_RWAIT);
	assign hresp     = 1'b0;

	// ==========================================================
	// Read data mux
	logic [31:0] rdMux;
	logic [7:0]  highView;

	// Buffered mode shows the buffer at the high address
	assign highView = bufferedAccess ? highBuf_r : count_r[15:8];

	always_comb
	begin
		unique case (dAddr_r)
			OFS_COUNT_LOW:  rdMux = {24'h000000, count_r[7:0]};
			OFS_COUNT_HIGH: rdMux = {24'h000000, highView};
			OFS_TIMER_CTRL: rdMux = {24'h000000, ctrl_r};
			OFS_GATE_CTRL:  rdMux = {24'h000000, gateCtrl_r};
			OFS_CLOCK_SEL:  rdMux = {30'h00000000, clkSel_r};
			OFS_IRQ_STATUS: rdMux = {31'h00000000, status_r};
			OFS_IRQ_MASK:   rdMux = {31'h00000000, mask_r};
			default:        rdMux = 32'h00000000;
		endcase
	end

	// Read data register
	always_ff @(posedge clk)
	begin
		if (rst)
			hrdata_r <= 32'h00000000;
		else if (busState_r == BUS_RWAIT)
			hrdata_r <= rdMux;
	end

	assign hrdata = hrdata_r;

	// ==========================================================
	// Control registers
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ctrl_r     <= CTRL_RESET;
			gateCtrl_r <= GATE_RESET;
			clkSel_r   <= CLKSEL_RESET;
			mask_r     <= 1'b0;
		end
		else
		begin
			if (wrCtrl)
				ctrl_r <= hwdata[7:0];
			if (wrGate)
				gateCtrl_r <= hwdata[7:0];
			if (wrClk)
				clkSel_r <= hwdata[1:0];
			if (wrMask)
				mask_r <= hwdata[STAT_OVF_BIT];
		end
	end

	// ==========================================================
	// Count enable and clock sources
	logic running;
	logic instrTick;
	logic extLevel;
	logic extRise;
	logic extFall;
	logic extLevelPrev_r;
	logic extEdge;
	logic srcTick;
	logic psTick;
	logic psClear;
	logic counterWrite;

	// Run only with run enable; gate only when gate enable is set
	assign running = runEnable && (!gateEnable || gateOpen);

	// Instruction cycle strobe
	assign instrTick = (instrPhase_r == INSTR_LAST);

	always_ff @(posedge clk)
	begin
		if (rst)
			instrPhase_r <= 2'h0;
		else
			instrPhase_r <= 2'(instrPhase_r + 2'h1);
	end

	sync_edge extSync
	(
		.clk   (clk),
		.rst   (rst),
		.din   (externalCountInput),
		.level (extLevel),
		.rise  (extRise)
	);

	// Any write that touches the live count
	assign counterWrite = wrLow || (wrHigh && !bufferedAccess);

	// Previous synchronised level, reset to the idle low level of the pin
	always_ff @(posedge clk)
	begin
		if (rst)
			extLevelPrev_r <= 1'b0;
		else
			extLevelPrev_r <= extLevel;
	end

	// Falling edge of the synchronised count input
	assign extFall = extLevelPrev_r && !extLevel;

	// Edge qualifier: arm only after a falling edge, so a low level
	// present at enable does not let the next rise through
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			armed_r   <= 1'b0;
			runPrev_r <= 1'b0;
		end
		else
		begin
			runPrev_r <= runEnable;
			if (counterWrite || (runEnable != runPrev_r) || !runEnable)
				armed_r <= 1'b0;
			else if (extFall)
				armed_r <= 1'b1;
		end
	end

	// Rising edges count only once armed
	assign extEdge = extRise && armed_r && (clkSel_r == CLK_EXT);

	// Synchronous mode holds an edge until the next instruction strobe
	always_ff @(posedge clk)
	begin
		if (rst || asyncMode || !running)
			extPend_r <= 1'b0;
		else if (extEdge)
			extPend_r <= 1'b1;
		else if (instrTick)
			extPend_r <= 1'b0;
	end

	// Source tick selection
	always_comb
	begin
		unique case (clkSel_r)
			CLK_INSTR: srcTick = instrTick;
			CLK_OSC:   srcTick = 1'b1;
			CLK_EXT:   srcTick = asyncMode ? extEdge : (extPend_r && instrTick);
			default:   srcTick = 1'b0;
		endcase
	end

	// Prescaler clears on any low write, or high write when not buffered
	assign psClear = wrLow || (wrHigh && !bufferedAccess);

	prescale_divider prescaler
	(
		.clk     (clk),
		.rst     (rst),
		.clear   (psClear),
		.sel     (prescaleSelect),
		.tickIn  (srcTick && running),
		.tickOut (psTick)
	);

	// ==========================================================
	// Live counter and high-byte buffer
	logic incr;
	logic overflow;

	assign incr     = psTick && !counterWrite && !wrHigh;
	assign overflow = incr && (count_r == 16'hFFFF);

	always_comb
	begin
		count_nxt = count_r;
		if (wrLow && bufferedAccess)
			count_nxt = {highBuf_r, hwdata[7:0]};
		else if (wrLow)
			count_nxt = {count_r[15:8], hwdata[7:0]};
		else if (wrHigh && !bufferedAccess)
			count_nxt = {hwdata[7:0], count_r[7:0]};
		else if (incr)
			count_nxt = 16'(count_r + 16'h0001);
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			count_r <= COUNT_RESET;
		else
			count_r <= count_nxt;
	end

	// Buffer catches high byte on low reads, or software high writes
	always_ff @(posedge clk)
	begin
		if (rst)
			highBuf_r <= 8'h00;
		else if (wrHigh && bufferedAccess)
			highBuf_r <= hwdata[7:0];
		else if (rdLowNow && bufferedAccess)
			highBuf_r <= count_r[15:8];
	end

	// ==========================================================
	// Overflow status, write one to clear, set wins
	always_ff @(posedge clk)
	begin
		if (rst)
			status_r <= 1'b0;
		else if (overflow)
			status_r <= 1'b1;
		else if (wrStat && hwdata[STAT_OVF_BIT])
			status_r <= 1'b0;
	end

	// Level interrupt while an unmasked flag is set
	assign irq = status_r & mask_r;

endmodule : gated_timer_counter
`default_nettype wire

// ==== tb/timer_checker.sv ====
// Purpose: Bus and interrupt checks at the timer top ports
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to the top module at the foot of this file
`timescale 1ns/100ps
`default_nettype none
module timer_checker
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Bus
	input  wire logic        hsel,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic        hready,
	input  wire logic        hreadyout,
	input  wire logic        hresp,
	input  wire logic [31:0] hrdata,
	// Interrupt
	input  wire logic        irq
);
	// ==========================================================
	// Helpers
	logic taken;
	logic wrPh_r;
	assign taken = hsel && hready && htrans[1];
	// Marks a write data phase
	always_ff @(posedge clk)
		wrPh_r <= !rst && taken && hwrite;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// ==========================================================
	// Properties
	property p_okay; hsel |-> hresp == 1'b0; endproperty
	a_okay: assert property (p_okay) else $error("error response");
	property p_rdwait; taken && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
	a_rdwait: assert property (p_rdwait) else $error("read wait wrong");
	property p_wr0; taken && hwrite |=> hreadyout; endproperty
	a_wr0: assert property (p_wr0) else $error("write stalled");
	property p_cause; $fell(hreadyout) |-> $past(taken && !hwrite); endproperty
	a_cause: assert property (p_cause) else $error("stall without read");
	property p_resv; $rose(hreadyout) |-> hrdata[31:8] == 24'h0; endproperty
	a_resv: assert property (p_resv) else $error("upper read bits set");
	property p_hold; $changed(hrdata) && !$past(rst) |-> !$past(hreadyout); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_rst; $fell(rst) |-> hreadyout && !irq && hrdata == 32'h0; endproperty
	a_rst: assert property (p_rst) else $error("bad state after reset");
	property p_irqfall; $fell(irq) |-> $past(wrPh_r); endproperty
	a_irqfall: assert property (p_irqfall) else $error("irq dropped alone");
	// Main scenarios
	c_read: cover property (taken && !hwrite);
	c_irq: cover property ($rose(irq));
	c_clear: cover property ($fell(irq));
endmodule : timer_checker

bind gated_timer_counter timer_checker timer_checker_inst (.clk(clk), .rst(rst),
	.hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq));
`default_nettype wire

// ==== tb/count_source.sv ====
// Purpose: External count input and gate source
// Assumes: Levels change just after a clock edge
// Notes:   Pulse widths set per call, prompt or slow
`timescale 1ns/100ps
`default_nettype none
module count_source
(
	// Clock
	input  wire logic clk,
	// Levels
	output logic      extIn,
	output logic      gate
);
	// Idle levels
	initial
	begin
		extIn = 1'b0;
		gate  = 1'b0;
	end
	// Count input level
	task automatic setLevel(input logic l);
		@(posedge clk);
		extIn <= l;
	endtask : setLevel
	// Fall then rise, w+1 clocks each half
	task automatic pulses(input int n, input int w);
		repeat (n)
		begin
			setLevel(1'b0);
			repeat (w) @(posedge clk);
			setLevel(1'b1);
			repeat (w) @(posedge clk);
		end
	endtask : pulses
	// Gate level from an unrelated source
	task automatic setGate(input logic g);
		@(posedge clk);
		gate <= g;
	endtask : setGate
endmodule : count_source
`default_nettype wire

// ==== tb/tb.sv ====
// Purpose: Self-checking bench for the gated timer
// Assumes: Word accesses, hready looped back
// Notes:   One task per scenario
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin errorCnt++; \
	$display("wrong value at %0t: got %h exp %h", $time, a, e); end end
module tb;
	import timer_pkg::*;
	localparam logic [31:0] RUN = 32'h1 << CTRL_RUN_BIT;
	localparam logic [31:0] BUF = 32'h1 << CTRL_BUF_BIT;
	localparam logic [31:0] ASY = 32'h1 << CTRL_ASYNC_BIT;
	logic        clk, rst, hsel, hwrite, hreadyout, hresp, irq, extIn, gate;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata;
	int          errorCnt, checked;

	// Clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	gated_timer_counter gated_timer_counter_inst (.clk(clk), .rst(rst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.externalCountInput(extIn), .gateOpen(gate), .irq(irq));
	count_source count_source_inst (.clk(clk), .extIn(extIn), .gate(gate));

	// ==========================================================
	// Bus access
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] q);
		hsel   <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		haddr  <= {27'h0, a};
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask : bus
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr
	task automatic rc(input logic [4:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		`CHK(q, e)
	endtask : rc
	function automatic logic near(input logic [31:0] q, input int e);
		return (q + 3 >= e) && (q <= e + 3);
	endfunction : near
	// Runs 66 clocks from a cleared count
	task automatic runFor(input logic [1:0] s, input logic [31:0] c, output logic [31:0] q);
		wr(OFS_CLOCK_SEL, {30'h0, s});
		wr(OFS_COUNT_HIGH, 32'h0);
		wr(OFS_COUNT_LOW, 32'h0);
		wr(OFS_TIMER_CTRL, c);
		repeat (64) @(posedge clk);
		wr(OFS_TIMER_CTRL, 32'h0);
		bus(1'b0, OFS_COUNT_LOW, 32'h0, q);
	endtask : runFor

	// ==========================================================
	// Scenarios
	task automatic tReset();
		for (int a = 0; a < 32; a += 4)
			rc(5'(a), 32'h0);
		wr(5'h1C, 32'hFF);
		rc(5'h1C, 32'h0);
	endtask : tReset
	task automatic tBuf();
		wr(OFS_COUNT_HIGH, 32'h05);
		wr(OFS_COUNT_LOW, 32'h06);
		rc(OFS_COUNT_LOW, 32'h06);
		wr(OFS_TIMER_CTRL, BUF);
		rc(OFS_TIMER_CTRL, BUF);
		wr(OFS_COUNT_HIGH, 32'h77);
		rc(OFS_COUNT_HIGH, 32'h77);
		rc(OFS_COUNT_LOW, 32'h06);
		rc(OFS_COUNT_HIGH, 32'h05);
		wr(OFS_COUNT_HIGH, 32'hAB);
		wr(OFS_COUNT_LOW, 32'hCD);
		wr(OFS_TIMER_CTRL, 32'h0);
		rc(OFS_COUNT_HIGH, 32'hAB);
		rc(OFS_COUNT_LOW, 32'hCD);
	endtask : tBuf
	task automatic tRates();
		logic [31:0] q;
		runFor(CLK_INSTR, RUN, q);
		`CHK(near(q, 16), 1'b1)
		for (int p = 0; p < 4; p++)
		begin
			runFor(CLK_OSC, RUN | 32'(p << CTRL_PS_LSB), q);
			`CHK(near(q, 66 >> p), 1'b1)
		end
		runFor(CLK_OSC, 32'h0, q);
		`CHK(q, 32'h0)
		// Unused source code selects nothing to count
		runFor(2'h3, RUN, q);
		`CHK(q, 32'h0)
	endtask : tRates
	task automatic tGate();
		logic [31:0] q;
		wr(OFS_GATE_CTRL, 32'h1 << GATE_EN_BIT);
		count_source_inst.setGate(1'b0);
		runFor(CLK_OSC, RUN, q);
		`CHK(q, 32'h0)
		count_source_inst.setGate(1'b1);
		runFor(CLK_OSC, RUN, q);
		`CHK(near(q, 66), 1'b1)
		wr(OFS_GATE_CTRL, 32'h0);
	endtask : tGate
	// Rise right after enabling from low must not count
	task automatic tExt(input logic [31:0] asy, input int w);
		count_source_inst.setLevel(1'b0);
		wr(OFS_CLOCK_SEL, {30'h0, CLK_EXT});
		wr(OFS_COUNT_LOW, 32'h0);
		wr(OFS_TIMER_CTRL, RUN | asy);
		repeat (8) @(posedge clk);
		count_source_inst.setLevel(1'b1);
		repeat (w) @(posedge clk);
		count_source_inst.pulses(3, w);
		repeat (16) @(posedge clk);
		wr(OFS_TIMER_CTRL, asy);
		rc(OFS_COUNT_LOW, 32'h3);
	endtask : tExt
	// Divide by 8 with a counter byte written every third clock
	task automatic preRun(input logic [31:0] m, input logic [4:0] a, output logic [31:0] q);
		wr(OFS_CLOCK_SEL, {30'h0, CLK_OSC});
		wr(OFS_COUNT_LOW, 32'h0);
		wr(OFS_TIMER_CTRL, m | RUN | 32'(3 << CTRL_PS_LSB));
		repeat (20)
		begin
			wr(a, 32'h0);
			@(posedge clk);
		end
		wr(OFS_TIMER_CTRL, m);
		bus(1'b0, OFS_COUNT_LOW, 32'h0, q);
	endtask : preRun
	task automatic tPre();
		logic [31:0] q;
		preRun(32'h0, OFS_COUNT_LOW, q);
		`CHK(q, 32'h0)
		preRun(BUF, OFS_COUNT_HIGH, q);
		`CHK(q >= 3, 1'b1)
	endtask : tPre
	task automatic chkIrq(input logic e);
		@(posedge clk);
		`CHK(irq, e)
	endtask : chkIrq
	task automatic tIrq();
		wr(OFS_CLOCK_SEL, {30'h0, CLK_OSC});
		wr(OFS_COUNT_HIGH, 32'hFF);
		wr(OFS_COUNT_LOW, 32'hFE);
		wr(OFS_IRQ_MASK, 32'h1);
		wr(OFS_TIMER_CTRL, RUN);
		repeat (8) @(posedge clk);
		wr(OFS_TIMER_CTRL, 32'h0);
		rc(OFS_IRQ_STATUS, 32'h1);
		rc(OFS_COUNT_HIGH, 32'h0);
		chkIrq(1'b1);
		wr(OFS_IRQ_MASK, 32'h0);
		chkIrq(1'b0);
		wr(OFS_IRQ_MASK, 32'h1);
		chkIrq(1'b1);
		wr(OFS_IRQ_STATUS, 32'h1);
		rc(OFS_IRQ_STATUS, 32'h0);
		chkIrq(1'b0);
	endtask : tIrq

	// ==========================================================
	// Verdict
	task automatic finish_test();
		$display("checks %0d errors %0d", checked, errorCnt);
		if (errorCnt == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : finish_test
	// Main sequence
	initial
	begin
		{rst, hsel, hwrite, htrans, haddr, hwdata} = {5'h18, 64'h0};
		errorCnt = 0;
		checked = 0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		tReset();
		tBuf();
		tRates();
		tGate();
		tExt(32'h0, 6);
		tExt(ASY, 3);
		tPre();
		tIrq();
		finish_test();
	end
	// Watchdog
	initial
	begin
		repeat (20000) @(posedge clk);
		errorCnt++;
		finish_test();
	end
endmodule : tb
`default_nettype wire
